// [hw/pls_pkg.sv]
// Constants and types shared by the PHY link side signalling block.
package pls_pkg;
	localparam int MCLK_PERIOD_NS = 100;
	localparam int LINK_CLK_PERIOD_NS = 800;
	localparam int LINK_CLK_HALF_CYC = (LINK_CLK_PERIOD_NS / MCLK_PERIOD_NS) / 2;
	localparam int STATUS_W = 16;
	localparam int REQ_W = 8;
	localparam int CTL_W = 2;
	localparam int DATA_W = 8;
	localparam logic [1:0] PWR_D0 = 2'h0;
	localparam logic [1:0] PWR_D2 = 2'h2;
	localparam logic [1:0] PWR_D3 = 2'h3;
	localparam logic [CTL_W-1:0] CTL_RST = 2'h0;
	localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
	typedef enum logic [1:0] {
		PLS_RX_IDLE = 2'b01,
		PLS_RX_SHIFT = 2'b10
	} pls_rx_state_t;
	typedef enum logic [1:0] {
		PLS_RQ_IDLE = 2'b01,
		PLS_RQ_SHIFT = 2'b10
	} pls_rq_state_t;
endpackage

// [hw/pls_phy_link_side.sv]
// Link side of the PHY-link signalling: power, status, wake, request, clocks, phase bus.
// What this block does
// - Wake notification is acted on only while link power indication is low.
// - Wake in uninitialised D0, D2 or D3 sets the sticky wake event status.
// - Link drives its service request output to start a request to the PHY.
// - Two-bit phase control bus shows the interface phase, whoever drives it.
// - After interface reset the PHY owns the phase bus; link drivers off.
// - PHY-driven phase bus values follow the PHY clock; link samples there.
// - Link-driven phase bus values launch with the link clock output.
// - Link generates its own clock on a dedicated output to the PHY.
// - Eight-bit data bus shares the phase bus ownership and clock rules.
`timescale 1ns/100ps
module pls_phy_link_side #(
	parameter int LINK_CLK_HALF = pls_pkg::LINK_CLK_HALF_CYC,
	parameter int STATUS_W = pls_pkg::STATUS_W,
	parameter int REQ_W = pls_pkg::REQ_W
) (
	input wire logic i_mclk,
	input wire logic i_rst_b,
	input wire logic i_link_power_en,
	input wire logic [1:0] i_pwr_state,
	input wire logic i_d0_initialized,
	input wire logic i_wake_status_clr,
	input wire logic i_phy_clock,
	input wire logic i_phy_status_serial_in,
	input wire logic i_wake_notify_line,
	input wire logic i_req_valid,
	input wire logic [REQ_W-1:0] i_req_bits,
	input wire logic i_if_reset,
	input wire logic i_link_own,
	input wire logic [pls_pkg::CTL_W-1:0] i_tx_ctl,
	input wire logic [pls_pkg::DATA_W-1:0] i_tx_data,
	input wire logic [pls_pkg::CTL_W-1:0] i_phase_control_bus_in,
	input wire logic [pls_pkg::DATA_W-1:0] i_data_bus_in,
	output logic o_link_power_indicator,
	output logic o_wake_event_status,
	output logic o_wake_event,
	output logic [STATUS_W-1:0] o_phy_status_word,
	output logic o_phy_status_valid,
	output logic o_req_ready,
	output logic o_link_service_request,
	output logic o_link_side_clock,
	output logic o_link_owns_bus,
	output logic [pls_pkg::CTL_W-1:0] o_phase_control_bus_out,
	output logic o_phase_control_bus_oe,
	output logic [pls_pkg::DATA_W-1:0] o_data_bus_out,
	output logic o_data_bus_oe,
	output logic [pls_pkg::CTL_W-1:0] o_rx_ctl,
	output logic [pls_pkg::DATA_W-1:0] o_rx_data,
	output logic o_rx_valid
);
	typedef struct packed {
		logic [7:0] div;
		logic link_clk;
		logic pclk_s1;
		logic pclk_s2;
		logic pclk_d;
		logic stat_s1;
		logic stat_s2;
		logic wake_s1;
		logic wake_s2;
		logic wake_d;
		logic [pls_pkg::CTL_W-1:0] ctl_s1;
		logic [pls_pkg::CTL_W-1:0] ctl_s2;
		logic [pls_pkg::DATA_W-1:0] dat_s1;
		logic [pls_pkg::DATA_W-1:0] dat_s2;
		logic pwr_ind;
		logic wake_sts;
		logic wake_pulse;
		pls_pkg::pls_rx_state_t rx_st;
		logic [7:0] st_cnt;
		logic [STATUS_W-1:0] st_sh;
		logic [STATUS_W-1:0] st_word;
		logic st_valid;
		pls_pkg::pls_rq_state_t rq_st;
		logic [REQ_W-1:0] rq_sh;
		logic [7:0] rq_cnt;
		logic rq_out;
		logic own;
		logic [pls_pkg::CTL_W-1:0] ctl_out;
		logic [pls_pkg::DATA_W-1:0] dat_out;
		logic [pls_pkg::CTL_W-1:0] rx_ctl;
		logic [pls_pkg::DATA_W-1:0] rx_dat;
		logic rx_valid;
	} pls_state_t;

	localparam pls_state_t RST_STATE = '{
		div: 8'h00, link_clk: 1'b0, pclk_s1: 1'b0, pclk_s2: 1'b0, pclk_d: 1'b0,
		stat_s1: 1'b0, stat_s2: 1'b0, wake_s1: 1'b0, wake_s2: 1'b0, wake_d: 1'b0,
		ctl_s1: pls_pkg::CTL_RST, ctl_s2: pls_pkg::CTL_RST,
		dat_s1: pls_pkg::DATA_RST, dat_s2: pls_pkg::DATA_RST,
		pwr_ind: 1'b0, wake_sts: 1'b0, wake_pulse: 1'b0,
		rx_st: pls_pkg::PLS_RX_IDLE, st_cnt: 8'h00, st_sh: '0, st_word: '0,
		st_valid: 1'b0, rq_st: pls_pkg::PLS_RQ_IDLE, rq_sh: '0, rq_cnt: 8'h00,
		rq_out: 1'b0, own: 1'b0, ctl_out: pls_pkg::CTL_RST,
		dat_out: pls_pkg::DATA_RST, rx_ctl: pls_pkg::CTL_RST,
		rx_dat: pls_pkg::DATA_RST, rx_valid: 1'b0
	};

	localparam logic [7:0] HALF_LAST = 8'(LINK_CLK_HALF - 1);
	localparam logic [7:0] STATUS_LAST = 8'(STATUS_W - 1);
	localparam logic [7:0] REQ_LAST = 8'(REQ_W - 1);

	pls_state_t cur_ff;
	pls_state_t nxt_st;
	logic link_clk_rise;
	logic pclk_rise;
	logic wake_rise;
	logic wake_gate;

	always_comb begin
		nxt_st = cur_ff;
		nxt_st.wake_pulse = 1'b0;
		nxt_st.st_valid = 1'b0;
		nxt_st.rx_valid = 1'b0;
		// Two-stage synchronisers (link power enable has one register); logic reads the last stage, plus one more delay stage on PHY clock and wake for edge detection.
		nxt_st.pclk_s1 = i_phy_clock;
		nxt_st.pclk_s2 = cur_ff.pclk_s1;
		nxt_st.pclk_d = cur_ff.pclk_s2;
		nxt_st.stat_s1 = i_phy_status_serial_in;
		nxt_st.stat_s2 = cur_ff.stat_s1;
		nxt_st.wake_s1 = i_wake_notify_line;
		nxt_st.wake_s2 = cur_ff.wake_s1;
		nxt_st.wake_d = cur_ff.wake_s2;
		nxt_st.ctl_s1 = i_phase_control_bus_in;
		nxt_st.ctl_s2 = cur_ff.ctl_s1;
		nxt_st.dat_s1 = i_data_bus_in;
		nxt_st.dat_s2 = cur_ff.dat_s1;
		nxt_st.pwr_ind = i_link_power_en;

		// Link clock divider; the rising edge is the launch point for the service request, bus takeover and link-driven bus values.
		link_clk_rise = 1'b0;
		if (cur_ff.div == HALF_LAST) begin
			nxt_st.div = 8'h00;
			nxt_st.link_clk = ~cur_ff.link_clk;
			link_clk_rise = ~cur_ff.link_clk;
		end else begin
			nxt_st.div = cur_ff.div + 8'h01;
		end

		pclk_rise = cur_ff.pclk_s2 & ~cur_ff.pclk_d;
		wake_rise = cur_ff.wake_s2 & ~cur_ff.wake_d;
		wake_gate = ~cur_ff.pwr_ind & ((i_pwr_state == pls_pkg::PWR_D0 & ~i_d0_initialized) |
			i_pwr_state == pls_pkg::PWR_D2 | i_pwr_state == pls_pkg::PWR_D3);

		// Sticky wake status: a new event in the clear cycle wins over the clear.
		if (i_wake_status_clr) begin
			nxt_st.wake_sts = 1'b0;
		end
		if (wake_rise & wake_gate) begin
			nxt_st.wake_sts = 1'b1;
			nxt_st.wake_pulse = 1'b1;
		end

		// Serial status: a high start bit, then STATUS_W bits MSB first on PHY clock edges.
		if (pclk_rise) begin
			case (cur_ff.rx_st)
				pls_pkg::PLS_RX_IDLE: begin
					if (cur_ff.stat_s2) begin
						nxt_st.rx_st = pls_pkg::PLS_RX_SHIFT;
						nxt_st.st_cnt = 8'h00;
					end
				end
				pls_pkg::PLS_RX_SHIFT: begin
					nxt_st.st_sh = {cur_ff.st_sh[STATUS_W-2:0], cur_ff.stat_s2};
					nxt_st.st_cnt = cur_ff.st_cnt + 8'h01;
					if (cur_ff.st_cnt == STATUS_LAST) begin
						nxt_st.st_word = {cur_ff.st_sh[STATUS_W-2:0], cur_ff.stat_s2};
						nxt_st.st_valid = 1'b1;
						nxt_st.rx_st = pls_pkg::PLS_RX_IDLE;
					end
				end
				default: nxt_st.rx_st = pls_pkg::PLS_RX_IDLE;
			endcase
		end

		// Service request: start bit then REQ_W bits MSB first, one per link clock.
		case (cur_ff.rq_st)
			pls_pkg::PLS_RQ_IDLE: begin
				if (i_req_valid) begin
					nxt_st.rq_sh = i_req_bits;
					nxt_st.rq_cnt = 8'h00;
					nxt_st.rq_st = pls_pkg::PLS_RQ_SHIFT;
				end
			end
			pls_pkg::PLS_RQ_SHIFT: begin
				if (link_clk_rise) begin
					if (cur_ff.rq_cnt == 8'h00) begin
						nxt_st.rq_out = 1'b1;
					end else begin
						nxt_st.rq_out = cur_ff.rq_sh[REQ_W-1];
						nxt_st.rq_sh = {cur_ff.rq_sh[REQ_W-2:0], 1'b0};
					end
					nxt_st.rq_cnt = cur_ff.rq_cnt + 8'h01;
					if (cur_ff.rq_cnt == REQ_LAST + 8'h01) begin
						nxt_st.rq_st = pls_pkg::PLS_RQ_IDLE;
					end
				end
			end
			default: nxt_st.rq_st = pls_pkg::PLS_RQ_IDLE;
		endcase
		if (cur_ff.rq_st == pls_pkg::PLS_RQ_IDLE & link_clk_rise) begin
			nxt_st.rq_out = 1'b0;
		end

		// Bus ownership is taken and link-driven values launch only with the link clock; interface reset drops ownership at once.
		if (i_if_reset) begin
			nxt_st.own = 1'b0;
		end else if (link_clk_rise) begin
			nxt_st.own = i_link_own;
			if (i_link_own) begin
				nxt_st.ctl_out = i_tx_ctl;
				nxt_st.dat_out = i_tx_data;
			end
		end

		// While the PHY drives, capture the buses on its clock edge.
		if (pclk_rise & ~cur_ff.own) begin
			nxt_st.rx_ctl = cur_ff.ctl_s2;
			nxt_st.rx_dat = cur_ff.dat_s2;
			nxt_st.rx_valid = 1'b1;
		end
	end

	always_ff @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			cur_ff <= RST_STATE;
		end else begin
			cur_ff <= nxt_st;
		end
	end

	assign o_link_power_indicator = cur_ff.pwr_ind;
	assign o_wake_event_status = cur_ff.wake_sts;
	assign o_wake_event = cur_ff.wake_pulse;
	assign o_phy_status_word = cur_ff.st_word;
	assign o_phy_status_valid = cur_ff.st_valid;
	assign o_req_ready = (cur_ff.rq_st == pls_pkg::PLS_RQ_IDLE);
	assign o_link_service_request = cur_ff.rq_out;
	assign o_link_side_clock = cur_ff.link_clk;
	assign o_link_owns_bus = cur_ff.own;
	assign o_phase_control_bus_out = cur_ff.ctl_out;
	assign o_phase_control_bus_oe = cur_ff.own;
	assign o_data_bus_out = cur_ff.dat_out;
	assign o_data_bus_oe = cur_ff.own;
	assign o_rx_ctl = cur_ff.rx_ctl;
	assign o_rx_data = cur_ff.rx_dat;
	assign o_rx_valid = cur_ff.rx_valid;
endmodule

// [testbench/pls_phy_link_side_checker.sv]
// Concurrent checks on the ports of the PHY link side block.
`timescale 1ns/100ps
module pls_phy_link_side_checker #(
	parameter int LINK_CLK_HALF = 4
) (
	input wire logic i_mclk,
	input wire logic i_rst_b,
	input wire logic [1:0] i_pwr_state,
	input wire logic i_d0_initialized,
	input wire logic i_wake_status_clr,
	input wire logic i_req_valid,
	input wire logic i_if_reset,
	input wire logic o_link_power_indicator,
	input wire logic o_wake_event_status,
	input wire logic o_wake_event,
	input wire logic o_req_ready,
	input wire logic o_link_service_request,
	input wire logic o_link_side_clock,
	input wire logic o_link_owns_bus,
	input wire logic [1:0] o_phase_control_bus_out,
	input wire logic o_phase_control_bus_oe,
	input wire logic o_data_bus_oe,
	input wire logic o_rx_valid
);
	localparam int RQ_MAX = 2 * LINK_CLK_HALF + 2;
	default clocking @(posedge i_mclk); endclocking
	default disable iff (!i_rst_b);
	sequence s_half;
		##LINK_CLK_HALF $fell(o_link_side_clock);
	endsequence
	property p_link_clk;
		$rose(o_link_side_clock) |-> s_half ##LINK_CLK_HALF o_link_side_clock;
	endproperty
	a_link_clk: assert property (p_link_clk) else $error("link clock period wrong");
	property p_wake_pwr;
		$rose(o_wake_event_status) |-> !$past(o_link_power_indicator);
	endproperty
	a_wake_pwr: assert property (p_wake_pwr) else $error("wake taken with power on");
	property p_wake_state;
		o_wake_event |-> $past(i_pwr_state) != 2'h1 && !($past(i_pwr_state) == 2'h0
			&& $past(i_d0_initialized));
	endproperty
	a_wake_state: assert property (p_wake_state) else $error("wake in wrong state");
	property p_sticky;
		o_wake_event_status && !i_wake_status_clr |=> o_wake_event_status;
	endproperty
	a_sticky: assert property (p_sticky) else $error("wake status lost");
	property p_pulse;
		o_wake_event |-> o_wake_event_status ##1 !o_wake_event;
	endproperty
	a_pulse: assert property (p_pulse) else $error("wake pulse wrong");
	property p_oe_rst;
		i_if_reset |=> !o_phase_control_bus_oe;
	endproperty
	a_oe_rst: assert property (p_oe_rst) else $error("bus kept after reset");
	property p_oe_tie;
		o_phase_control_bus_oe == o_data_bus_oe && o_data_bus_oe == o_link_owns_bus;
	endproperty
	a_oe_tie: assert property (p_oe_tie) else $error("enables disagree");
	property p_own;
		$rose(o_phase_control_bus_oe) |-> $rose(o_link_side_clock);
	endproperty
	a_own: assert property (p_own) else $error("takeover off link clock");
	property p_launch;
		$changed(o_phase_control_bus_out) |-> $rose(o_link_side_clock);
	endproperty
	a_launch: assert property (p_launch) else $error("phase out off link clock");
	property p_req;
		i_req_valid && o_req_ready |=> !o_req_ready ##[0:RQ_MAX] o_link_service_request;
	endproperty
	a_req: assert property (p_req) else $error("request not started");
	property p_rx;
		o_rx_valid |-> !$past(o_link_owns_bus);
	endproperty
	a_rx: assert property (p_rx) else $error("capture while owning");
endmodule
bind pls_phy_link_side pls_phy_link_side_checker #(.LINK_CLK_HALF(LINK_CLK_HALF)) chk_inst (.*);

// [testbench/pls_phy_model.sv]
// Behavioural model of the PHY facing the link side block.
`timescale 1ns/100ps
module pls_phy_model (
	input wire logic i_link_oe,
	input wire logic [1:0] i_link_ctl,
	input wire logic [7:0] i_link_data,
	output logic o_pclk,
	output logic o_status,
	output logic o_wake,
	output logic [1:0] o_ctl_pin,
	output logic [7:0] o_data_pin
);
	initial begin
		o_pclk = 1'b0;
		o_status = 1'b0;
		o_wake = 1'b0;
		forever #400 o_pclk = ~o_pclk;
	end
	logic [1:0] phy_ctl = 2'h1;
	logic [7:0] phy_dat = 8'ha5;
	// The PHY lets go of both buses while the link owns them.
	assign o_ctl_pin = i_link_oe ? i_link_ctl : phy_ctl;
	assign o_data_pin = i_link_oe ? i_link_data : phy_dat;
	// PHY-driven values change on the falling PHY clock so they stand at its rising edge.
	task automatic drive_bus(input logic [1:0] c, input logic [7:0] d);
		@(negedge o_pclk);
		phy_ctl = c;
		phy_dat = d;
	endtask
	task automatic send_status(input logic [15:0] w);
		for (int i = 16; i >= 0; i--) begin
			@(negedge o_pclk);
			o_status = (i == 16) ? 1'b1 : w[i];
		end
		@(negedge o_pclk);
		o_status = 1'b0;
	endtask
	task automatic wake();
		#7;
		o_wake = 1'b1;
		#1000;
		o_wake = 1'b0;
	endtask
endmodule

// [testbench/tb_top.sv]
// Self-checking bench for the PHY link side block.
`timescale 1ns/100ps
module tb_top;
	logic i_mclk = 1'b0, i_rst_b = 1'b0, i_link_power_en = 1'b0, i_d0_initialized = 1'b0;
	logic i_wake_status_clr = 1'b0, i_req_valid = 1'b0, i_if_reset = 1'b0, i_link_own = 1'b0;
	logic [1:0] i_pwr_state = 2'h0, i_tx_ctl = 2'h0, i_phase_control_bus_in, o_rx_ctl;
	logic [7:0] i_req_bits = 8'h00, i_tx_data = 8'h00, i_data_bus_in, o_data_bus_out, o_rx_data;
	logic i_phy_clock, i_phy_status_serial_in, i_wake_notify_line, o_link_power_indicator;
	logic o_wake_event_status, o_wake_event, o_phy_status_valid, o_req_ready;
	logic o_link_side_clock, o_link_owns_bus, o_phase_control_bus_oe, o_data_bus_oe, o_rx_valid;
	logic o_link_service_request;
	logic [1:0] o_phase_control_bus_out;
	logic [15:0] o_phy_status_word;
	int bad_count = 0, n_tests = 0, cycles = 0;
	int n_valid = 0;
	pls_phy_link_side pls_phy_link_side_inst (.*);
	pls_phy_model pls_phy_model_inst (.i_link_oe(o_phase_control_bus_oe),
		.i_link_ctl(o_phase_control_bus_out), .i_link_data(o_data_bus_out),
		.o_pclk(i_phy_clock), .o_status(i_phy_status_serial_in), .o_wake(i_wake_notify_line),
		.o_ctl_pin(i_phase_control_bus_in), .o_data_pin(i_data_bus_in));
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		n_tests++;
		if (g !== e) begin
			bad_count++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic print_verdict();
		if (bad_count == 0 && n_tests > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic t_wake();
		logic [4:0] tbl [6] = '{5'h0d, 5'h1c, 5'h04, 5'h02, 5'h01, 5'h09};
		foreach (tbl[k]) begin
			@(posedge i_mclk);
			{i_link_power_en, i_pwr_state, i_d0_initialized} <= tbl[k][4:1];
			i_wake_status_clr <= 1'b1;
			@(posedge i_mclk);
			i_wake_status_clr <= 1'b0;
			repeat (3) @(posedge i_mclk);
			pls_phy_model_inst.wake();
			repeat (6) @(posedge i_mclk);
			chk("wake_status", 16'(tbl[k][0]), 16'(o_wake_event_status));
		end
	endtask
	task automatic t_status();
		int v0;
		v0 = n_valid;
		pls_phy_model_inst.send_status(16'hb3c1);
		repeat (8) @(posedge i_mclk);
		chk("status_word", 16'hb3c1, o_phy_status_word);
		chk("status_valid_pulses", 16'h0001, 16'(n_valid - v0));
	endtask
	task automatic t_req();
		logic [7:0] got = 8'h00;
		@(posedge i_mclk);
		i_req_bits <= 8'h96;
		i_req_valid <= 1'b1;
		@(posedge i_mclk);
		i_req_valid <= 1'b0;
		for (int k = 0; k < 3 && !o_link_service_request; k++) @(posedge o_link_side_clock) #1;
		for (int k = 7; k >= 0; k--) begin
			@(posedge o_link_side_clock) #1;
			got[k] = o_link_service_request;
		end
		chk("request_bits", 16'h0096, 16'(got));
	endtask
	task automatic t_bus();
		chk("oe_after_reset", 16'h0000, 16'(o_phase_control_bus_oe));
		repeat (12) @(posedge i_mclk);
		chk("rx_ctl", 16'h0001, 16'(o_rx_ctl));
		chk("rx_data", 16'h00a5, 16'(o_rx_data));
		pls_phy_model_inst.drive_bus(2'h3, 8'h5a);
		repeat (12) @(posedge i_mclk);
		chk("rx_ctl_next", 16'h0003, 16'(o_rx_ctl));
		chk("rx_data_next", 16'h005a, 16'(o_rx_data));
		{i_link_own, i_tx_ctl, i_tx_data} <= {1'b1, 2'h2, 8'h3c};
		repeat (20) @(posedge i_mclk);
		chk("link_ctl_pin", 16'h0002, 16'(i_phase_control_bus_in));
		chk("link_data_pin", 16'h003c, 16'(i_data_bus_in));
		i_if_reset <= 1'b1;
		i_link_own <= 1'b0;
		@(posedge i_mclk);
		i_if_reset <= 1'b0;
		@(posedge i_mclk) #1;
		chk("oe_after_if_reset", 16'h0000, 16'(o_phase_control_bus_oe));
	endtask
	initial begin
		forever #50 i_mclk = ~i_mclk;
	end
	// Status valid is a one-cycle pulse; counting on the falling edge sees it settled.
	always @(negedge i_mclk) begin
		if (o_phy_status_valid === 1'b1) begin
			n_valid++;
		end
	end
	always @(posedge i_mclk) begin
		cycles++;
		if (cycles == 20000) begin
			bad_count++;
			print_verdict();
		end
	end
	initial begin
		repeat (6) @(posedge i_mclk);
		i_rst_b <= 1'b1;
		t_bus();
		t_wake();
		t_status();
		t_req();
		print_verdict();
	end
endmodule
